//--- hdl/gpbk_pkg.sv
package gpbk_pkg;

  // configuration register indexes
  localparam logic [7:0] IDX_PORT_ENABLE = 8'h30;
  localparam logic [7:0] IDX_BASE_HIGH = 8'h60;
  localparam logic [7:0] IDX_BASE_LOW = 8'h61;
  localparam logic [7:0] IDX_IRQ_SELECT = 8'h70;
  localparam logic [7:0] IDX_DIRECTION = 8'hF0;
  localparam logic [7:0] IDX_OUT_VALUE = 8'hF1;
  localparam logic [7:0] IDX_PIN_LEVEL = 8'hF2;
  localparam logic [7:0] IDX_DRIVE_TYPE = 8'hF3;

  // field positions and widths
  localparam int ENABLE_BIT_POS = 0;
  localparam int IRQ_FIELD_W = 4;
  localparam int BANK_PINS = 6;

  // runtime port offsets from the aligned base
  localparam logic [15:0] INDEX_PORT_OFS = 16'h0005;
  localparam logic [15:0] DATA_PORT_OFS = 16'h0006;

  // reset values
  localparam logic RST_PORT_ENABLE = 1'h0;
  localparam logic [7:0] RST_BASE_HIGH = 8'h00;
  localparam logic [7:0] RST_BASE_LOW = 8'h00;
  localparam logic [3:0] RST_IRQ_FIELD = 4'h0;
  localparam logic [5:0] RST_DIRECTION = 6'h00;
  localparam logic [5:0] RST_OUT_VALUE = 6'h3F;
  localparam logic [5:0] RST_DRIVE_TYPE = 6'h00;
  localparam logic [7:0] RST_RUN_INDEX = 8'h00;

endpackage : gpbk_pkg

//--- hdl/gpbk_pad_ctrl.sv
`timescale 1ns/1ps
module gpbk_pad_ctrl #(
  parameter int PINS = 6
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // pin settings
  input wire logic [PINS-1:0] direction,
  input wire logic [PINS-1:0] out_value,
  input wire logic [PINS-1:0] push_pull,
  // pad side
  output logic [PINS-1:0] pad_out,
  output logic [PINS-1:0] pad_oe
);

  logic [PINS-1:0] out_d;
  logic [PINS-1:0] oe_d;
  logic [PINS-1:0] out_q;
  logic [PINS-1:0] oe_q;

  // push-pull drives both levels; open drain only ever pulls low
  assign out_d = push_pull & out_value; // [R7] [R9] [R10]
  assign oe_d = direction & (push_pull | ~out_value); // [R6] [R9] [R10]

  // pad controls registered so the pins never see decode glitches
  always_ff @(posedge clk) begin
    if (!nrst) begin
      out_q <= '0;
      oe_q <= '0;
    end else begin
      out_q <= out_d;
      oe_q <= oe_d;
    end
  end

  assign pad_out = out_q;
  assign pad_oe = oe_q;

endmodule : gpbk_pad_ctrl

//--- hdl/gpbk_port.sv
`timescale 1ns/1ps
// What this block does
// R1 - Bit 0 of the enable register turns the runtime index/data port off (0) or on (1).
// R2 - The base-high register holds the upper byte of the 16-bit port base and is read/write.
// R3 - The base-low register holds the lower byte of the port base, read/write, reset to zero.
// R4 - The index port sits at the base with bits 1:0 cleared plus 5, the data port at plus 6.
// R5 - A 4-bit read/write field in bits 3:0 picks the interrupt channel, reset to zero.
// R6 - Each of six pins has a direction bit, 0 input and 1 output, resetting to input.
// R7 - A pin in output mode drives its output value bit, and each value bit resets to 1.
// R8 - A read-only status register returns the present level of each of the six pins.
// R9 - A drive-select bit per pin picks open drain (0) or push-pull (1), resetting to open drain.
// R10 - Open drain pulls low for value 0 and floats for value 1; reserved bits read as zero.
module gpbk_port #(
  parameter int PINS = gpbk_pkg::BANK_PINS
) (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic NRST,
  // configuration register access
  input wire logic [7:0] CFG_INDEX,
  input wire logic [7:0] CFG_WDATA,
  input wire logic CFG_WR,
  input wire logic CFG_RD,
  output logic [7:0] CFG_RDATA,
  // host i/o port cycles
  input wire logic [15:0] IO_ADDR,
  input wire logic [7:0] IO_WDATA,
  input wire logic IO_WR,
  input wire logic IO_RD,
  output logic [7:0] IO_RDATA,
  output logic IO_HIT,
  // interrupt routing
  output logic [3:0] IRQ_CHANNEL,
  // bank 0 pins
  input wire logic [PINS-1:0] PIN_IN,
  output logic [PINS-1:0] PIN_OUT,
  output logic [PINS-1:0] PIN_OE
);

  logic port_enable_bit_q;
  logic port_enable_bit_d;
  logic [7:0] base_upper_byte_q;
  logic [7:0] base_upper_byte_d;
  logic [7:0] base_lower_byte_q;
  logic [7:0] base_lower_byte_d;
  logic [3:0] irq_channel_field_q;
  logic [3:0] irq_channel_field_d;
  logic [PINS-1:0] direction_q;
  logic [PINS-1:0] direction_d;
  logic [PINS-1:0] out_value_q;
  logic [PINS-1:0] out_value_d;
  logic [PINS-1:0] push_pull_select_q;
  logic [PINS-1:0] push_pull_select_d;
  logic [7:0] run_index_q;
  logic [7:0] run_index_d;
  logic [7:0] cfg_rdata_q;
  logic [7:0] cfg_rdata_d;
  logic [7:0] io_rdata_q;
  logic [7:0] io_rdata_d;

  // bank registers as seen through either access path; unused bits read zero
  function automatic logic [7:0] bank_read(
    input logic [7:0] idx,
    input logic [PINS-1:0] dir,
    input logic [PINS-1:0] val,
    input logic [PINS-1:0] lvl,
    input logic [PINS-1:0] drv
  );
    logic [7:0] r;
    r = 8'h00;
    case (idx)
      gpbk_pkg::IDX_DIRECTION: r[PINS-1:0] = dir;
      gpbk_pkg::IDX_OUT_VALUE: r[PINS-1:0] = val;
      gpbk_pkg::IDX_PIN_LEVEL: r[PINS-1:0] = lvl; // [R8]
      gpbk_pkg::IDX_DRIVE_TYPE: r[PINS-1:0] = drv;
      default: r = 8'h00; // [R10]
    endcase
    return r;
  endfunction : bank_read

  // runtime port decode on the base with its two low bits dropped
  logic [15:0] base_aligned;
  logic [15:0] index_port_addr;
  logic [15:0] data_port_addr;
  logic hit_index;
  logic hit_data;
  assign base_aligned = {base_upper_byte_q, base_lower_byte_q[7:2], 2'h0};
  assign index_port_addr = base_aligned + gpbk_pkg::INDEX_PORT_OFS; // [R4]
  assign data_port_addr = base_aligned + gpbk_pkg::DATA_PORT_OFS; // [R4]
  // a disabled port answers nothing, so the host bus sees no claim
  assign hit_index = port_enable_bit_q && (IO_ADDR == index_port_addr); // [R1]
  assign hit_data = port_enable_bit_q && (IO_ADDR == data_port_addr); // [R1]
  assign IO_HIT = (hit_index || hit_data) && (IO_WR || IO_RD);

  // configuration write decode
  logic cfg_wr_enable;
  logic cfg_wr_base_high;
  logic cfg_wr_base_low;
  logic cfg_wr_irq;
  assign cfg_wr_enable = CFG_WR && (CFG_INDEX == gpbk_pkg::IDX_PORT_ENABLE);
  assign cfg_wr_base_high = CFG_WR && (CFG_INDEX == gpbk_pkg::IDX_BASE_HIGH);
  assign cfg_wr_base_low = CFG_WR && (CFG_INDEX == gpbk_pkg::IDX_BASE_LOW);
  assign cfg_wr_irq = CFG_WR && (CFG_INDEX == gpbk_pkg::IDX_IRQ_SELECT);

  // bank writes come from either path; configuration wins a same-cycle clash
  logic run_data_wr;
  logic bank_wr;
  logic [7:0] bank_idx;
  logic [7:0] bank_wdata;
  assign run_data_wr = hit_data && IO_WR;
  assign bank_wr = CFG_WR || run_data_wr;
  assign bank_idx = CFG_WR ? CFG_INDEX : run_index_q;
  assign bank_wdata = CFG_WR ? CFG_WDATA : IO_WDATA;

  // next values of the configuration registers
  assign port_enable_bit_d = cfg_wr_enable ? CFG_WDATA[gpbk_pkg::ENABLE_BIT_POS]
                                           : port_enable_bit_q; // [R1]
  assign base_upper_byte_d = cfg_wr_base_high ? CFG_WDATA : base_upper_byte_q; // [R2]
  assign base_lower_byte_d = cfg_wr_base_low ? CFG_WDATA : base_lower_byte_q; // [R3]
  assign irq_channel_field_d = cfg_wr_irq ? CFG_WDATA[3:0] : irq_channel_field_q; // [R5]

  // next values of the pin bank; the level register has no write path
  assign direction_d = (bank_wr && bank_idx == gpbk_pkg::IDX_DIRECTION)
                       ? bank_wdata[PINS-1:0] : direction_q; // [R6]
  assign out_value_d = (bank_wr && bank_idx == gpbk_pkg::IDX_OUT_VALUE)
                       ? bank_wdata[PINS-1:0] : out_value_q; // [R7]
  assign push_pull_select_d = (bank_wr && bank_idx == gpbk_pkg::IDX_DRIVE_TYPE)
                              ? bank_wdata[PINS-1:0] : push_pull_select_q; // [R9]
  assign run_index_d = (hit_index && IO_WR) ? IO_WDATA : run_index_q;

  // configuration read mux; reserved upper bits stay zero
  logic [7:0] cfg_mux;
  assign cfg_mux =
    (CFG_INDEX == gpbk_pkg::IDX_PORT_ENABLE) ? {7'h00, port_enable_bit_q} :
    (CFG_INDEX == gpbk_pkg::IDX_BASE_HIGH) ? base_upper_byte_q : // [R2]
    (CFG_INDEX == gpbk_pkg::IDX_BASE_LOW) ? base_lower_byte_q : // [R3]
    (CFG_INDEX == gpbk_pkg::IDX_IRQ_SELECT) ? {4'h0, irq_channel_field_q} : // [R5] [R10]
    bank_read(CFG_INDEX, direction_q, out_value_q, PIN_IN, push_pull_select_q);
  assign cfg_rdata_d = CFG_RD ? cfg_mux : cfg_rdata_q;

  // runtime read: index port echoes the index, data port reads the bank
  logic [7:0] io_mux;
  assign io_mux = hit_index ? run_index_q
                : bank_read(run_index_q, direction_q, out_value_q, PIN_IN,
                            push_pull_select_q); // [R8]
  assign io_rdata_d = (IO_RD && (hit_index || hit_data)) ? io_mux : io_rdata_q;

  // configuration registers
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      port_enable_bit_q <= gpbk_pkg::RST_PORT_ENABLE;
      base_upper_byte_q <= gpbk_pkg::RST_BASE_HIGH;
      base_lower_byte_q <= gpbk_pkg::RST_BASE_LOW; // [R3]
      irq_channel_field_q <= gpbk_pkg::RST_IRQ_FIELD; // [R5]
    end else begin
      port_enable_bit_q <= port_enable_bit_d;
      base_upper_byte_q <= base_upper_byte_d;
      base_lower_byte_q <= base_lower_byte_d;
      irq_channel_field_q <= irq_channel_field_d;
    end
  end

  // pin bank and runtime index
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      direction_q <= gpbk_pkg::RST_DIRECTION[PINS-1:0]; // [R6]
      out_value_q <= gpbk_pkg::RST_OUT_VALUE[PINS-1:0]; // [R7]
      push_pull_select_q <= gpbk_pkg::RST_DRIVE_TYPE[PINS-1:0]; // [R9]
      run_index_q <= gpbk_pkg::RST_RUN_INDEX;
    end else begin
      direction_q <= direction_d;
      out_value_q <= out_value_d;
      push_pull_select_q <= push_pull_select_d;
      run_index_q <= run_index_d;
    end
  end

  // read data held until the next read
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      cfg_rdata_q <= 8'h00;
      io_rdata_q <= 8'h00;
    end else begin
      cfg_rdata_q <= cfg_rdata_d;
      io_rdata_q <= io_rdata_d;
    end
  end

  assign CFG_RDATA = cfg_rdata_q;
  assign IO_RDATA = io_rdata_q;
  assign IRQ_CHANNEL = irq_channel_field_q;

  // pad drive, one flop stage behind the settings
  gpbk_pad_ctrl #(
    .PINS(PINS)
  ) u_pads (
    .clk(CLK_SYS),
    .nrst(NRST),
    .direction(direction_q),
    .out_value(out_value_q),
    .push_pull(push_pull_select_q),
    .pad_out(PIN_OUT),
    .pad_oe(PIN_OE)
  );

endmodule : gpbk_port

//--- sim/gpbk_port_chk.sv
`timescale 1ns/1ps
module gpbk_port_chk #(
  parameter int PINS = 6
) (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic NRST,
  // register and port traffic
  input wire logic [7:0] CFG_INDEX,
  input wire logic [7:0] CFG_WDATA,
  input wire logic CFG_WR,
  input wire logic CFG_RD,
  input wire logic [7:0] CFG_RDATA,
  input wire logic [15:0] IO_ADDR,
  input wire logic IO_WR,
  input wire logic IO_RD,
  input wire logic [7:0] IO_RDATA,
  input wire logic IO_HIT,
  // routing and pins
  input wire logic [3:0] IRQ_CHANNEL,
  input wire logic [PINS-1:0] PIN_IN,
  input wire logic [PINS-1:0] PIN_OE
);
  // one clock domain, reset masks every check
  default clocking @(posedge CLK_SYS);
  endclocking
  default disable iff (!NRST);
  // shadow of the enable bit, so a claim can be held against the last write
  logic en_q;
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      en_q <= gpbk_pkg::RST_PORT_ENABLE;
    end else if (CFG_WR && CFG_INDEX == 8'h30) begin
      en_q <= CFG_WDATA[0];
    end
  end
  property p_hit_en; IO_HIT |-> en_q; endproperty
  a_hit_en: assert property (p_hit_en) else $error("port hit while disabled");
  property p_hit_strobe; IO_HIT |-> IO_WR || IO_RD; endproperty
  a_hit_strobe: assert property (p_hit_strobe) else $error("port hit without strobe");
  property p_hit_addr; IO_HIT |-> IO_ADDR[1:0] == 2'h1 || IO_ADDR[1:0] == 2'h2; endproperty
  a_hit_addr: assert property (p_hit_addr) else $error("port hit off offset");
  property p_rd_hold; !(IO_RD && IO_HIT) |=> $stable(IO_RDATA); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("port data moved");
  property p_irq; CFG_WR && CFG_INDEX == 8'h70 |=> IRQ_CHANNEL == $past(CFG_WDATA[3:0]); endproperty
  a_irq: assert property (p_irq) else $error("irq field not taken");
  property p_irq_hold; !(CFG_WR && CFG_INDEX == 8'h70) |=> $stable(IRQ_CHANNEL); endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq field moved");
  property p_lvl; CFG_RD && CFG_INDEX == 8'hF2 |=> CFG_RDATA == 8'($past(PIN_IN)); endproperty
  a_lvl: assert property (p_lvl) else $error("pin level read wrong");
  property p_en_rsv; CFG_RD && CFG_INDEX == 8'h30 |=> CFG_RDATA[7:1] == 7'h00; endproperty
  a_en_rsv: assert property (p_en_rsv) else $error("enable reserved set");
  property p_irq_rd;
    CFG_RD && CFG_INDEX == 8'h70 |=> CFG_RDATA == {4'h0, $past(IRQ_CHANNEL)};
  endproperty
  a_irq_rd: assert property (p_irq_rd) else $error("irq read wrong");
  // all pins made inputs must be released after the pad stage
  property p_dir_off; CFG_WR && CFG_INDEX == 8'hF0 && CFG_WDATA == 8'h00 |=> ##1 PIN_OE == '0;
  endproperty
  a_dir_off: assert property (p_dir_off) else $error("pin driven as input");
  c_io_rd: cover property (IO_RD && IO_HIT);
  c_io_wr: cover property (IO_WR && IO_HIT);
  c_lvl: cover property (CFG_RD && CFG_INDEX == 8'hF2);
endmodule : gpbk_port_chk

bind gpbk_port gpbk_port_chk #(.PINS(PINS)) u_gpbk_port_chk (.CLK_SYS(CLK_SYS), .NRST(NRST),
  .CFG_INDEX(CFG_INDEX), .CFG_WDATA(CFG_WDATA), .CFG_WR(CFG_WR), .CFG_RD(CFG_RD),
  .CFG_RDATA(CFG_RDATA), .IO_ADDR(IO_ADDR), .IO_WR(IO_WR), .IO_RD(IO_RD), .IO_RDATA(IO_RDATA),
  .IO_HIT(IO_HIT), .IRQ_CHANNEL(IRQ_CHANNEL), .PIN_IN(PIN_IN), .PIN_OE(PIN_OE));

//--- sim/gpbk_pad_model.sv
`timescale 1ns/1ps
module gpbk_pad_model (
  // pad drive from the port
  input wire logic [5:0] pin_out,
  input wire logic [5:0] pin_oe,
  // external parts pulling low
  input wire logic [5:0] ext_low,
  // resolved wire level
  output logic [5:0] pin_level
);
  // released pins float to the board pull-up unless pulled low
  assign pin_level = (pin_oe & pin_out) | (~pin_oe & ~ext_low);
endmodule : gpbk_pad_model

//--- sim/gpbk_port_bench.sv
`timescale 1ns/1ps
module gpbk_port_bench;
  logic CLK_SYS, NRST, CFG_WR, CFG_RD, IO_WR, IO_RD, IO_HIT;
  logic [7:0] CFG_INDEX, CFG_WDATA, CFG_RDATA, IO_WDATA, IO_RDATA;
  logic [15:0] IO_ADDR;
  logic [3:0] IRQ_CHANNEL;
  logic [5:0] PIN_IN, PIN_OUT, PIN_OE, ext_low;
  int failures = 0;
  int checked = 0;
  logic [7:0] ri [9] = '{8'h30, 8'h60, 8'h61, 8'h70, 8'hF0, 8'hF1, 8'hF2, 8'hF3, 8'h55};
  logic [7:0] re [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h3F, 8'h3F, 8'h00, 8'h00};
  logic [7:0] wi [6] = '{8'h60, 8'h61, 8'h70, 8'hF0, 8'h30, 8'hF2};
  logic [7:0] wd [6] = '{8'h12, 8'h37, 8'hFA, 8'hFF, 8'hFF, 8'h00};
  logic [7:0] we [6] = '{8'h12, 8'h37, 8'h0A, 8'h3F, 8'h01, 8'h3F};
  // device and its pads
  gpbk_port u_gpbk_port (.CLK_SYS(CLK_SYS), .NRST(NRST), .CFG_INDEX(CFG_INDEX),
    .CFG_WDATA(CFG_WDATA), .CFG_WR(CFG_WR), .CFG_RD(CFG_RD), .CFG_RDATA(CFG_RDATA),
    .IO_ADDR(IO_ADDR), .IO_WDATA(IO_WDATA), .IO_WR(IO_WR), .IO_RD(IO_RD), .IO_RDATA(IO_RDATA),
    .IO_HIT(IO_HIT), .IRQ_CHANNEL(IRQ_CHANNEL), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT),
    .PIN_OE(PIN_OE));
  gpbk_pad_model u_gpbk_pad_model (.pin_out(PIN_OUT), .pin_oe(PIN_OE), .ext_low(ext_low),
    .pin_level(PIN_IN));
  // 25 MHz clock
  initial begin
    CLK_SYS = 1'b0;
    forever #20 CLK_SYS = ~CLK_SYS;
  end
  task check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // one strobe cycle on either bus; reads compare after the answer lands
  task acc(input logic io, input logic wr, input logic [15:0] a, input logic [7:0] d);
    @(posedge CLK_SYS);
    IO_ADDR <= a;
    CFG_INDEX <= a[7:0];
    IO_WDATA <= d;
    CFG_WDATA <= d;
    IO_WR <= io & wr;
    IO_RD <= io & !wr;
    CFG_WR <= !io & wr;
    CFG_RD <= !io & !wr;
    @(posedge CLK_SYS);
    {IO_WR, IO_RD, CFG_WR, CFG_RD} <= 4'h0;
    if (!wr) begin
      @(negedge CLK_SYS);
      check(io ? IO_RDATA : CFG_RDATA, d);
    end
  endtask : acc
  // one read strobe; the claim is combinational, so look while the strobe stands
  task hit(input logic [15:0] a, input logic [7:0] exp);
    @(posedge CLK_SYS);
    IO_ADDR <= a;
    IO_RD <= 1'b1;
    @(negedge CLK_SYS);
    check({7'h00, IO_HIT}, exp);
    @(posedge CLK_SYS);
    IO_RD <= 1'b0;
  endtask : hit
  task stop_test;
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test
  // hang guard
  initial begin
    #2000000;
    failures++;
    stop_test;
  end
  // main sequence
  initial begin
    {NRST, IO_WR, IO_RD, CFG_WR, CFG_RD} = 5'h00;
    {IO_ADDR, CFG_INDEX, IO_WDATA, CFG_WDATA} = 40'h0;
    ext_low = 6'h00;
    repeat (12) @(posedge CLK_SYS);
    NRST <= 1'b1;
    for (int k = 0; k < 9; k++) acc(0, 0, {8'h00, ri[k]}, re[k]);
    for (int k = 0; k < 6; k++) begin
      acc(0, 1, {8'h00, wi[k]}, wd[k]);
      acc(0, 0, {8'h00, wi[k]}, we[k]);
    end
    check({4'h0, IRQ_CHANNEL}, 8'h0A);
    acc(1, 1, 16'h1239, 8'hF1);
    acc(1, 0, 16'h1239, 8'hF1);
    hit(16'h123A, 8'h01);
    acc(1, 1, 16'h123A, 8'h00);
    repeat (2) @(negedge CLK_SYS);
    check({2'h0, PIN_OE}, 8'h3F);
    check({2'h0, PIN_OUT}, 8'h00);
    acc(1, 1, 16'h1239, 8'hF3);
    acc(1, 1, 16'h123A, 8'h0F);
    acc(1, 1, 16'h1239, 8'hF1);
    acc(1, 1, 16'h123A, 8'h2A);
    ext_low <= 6'h20;
    repeat (2) @(negedge CLK_SYS);
    check({2'h0, PIN_OE}, 8'h1F);
    check({2'h0, PIN_OUT}, 8'h0A);
    acc(1, 1, 16'h1239, 8'hF2);
    acc(1, 0, 16'h123A, 8'h0A);
    acc(0, 0, 16'h00F1, 8'h2A);
    acc(1, 0, 16'h1235, 8'h0A);
    hit(16'h1235, 8'h00);
    acc(0, 1, 16'h0030, 8'h00);
    acc(1, 0, 16'h1239, 8'h0A);
    hit(16'h1239, 8'h00);
    acc(0, 1, 16'h00F0, 8'h00);
    repeat (2) @(negedge CLK_SYS);
    check({2'h0, PIN_OE}, 8'h00);
    // second reset in mid-run must bring back the defaults
    @(posedge CLK_SYS);
    NRST <= 1'b0;
    repeat (2) @(posedge CLK_SYS);
    NRST <= 1'b1;
    @(negedge CLK_SYS);
    check({4'h0, IRQ_CHANNEL}, 8'h00);
    acc(0, 0, 16'h00F1, 8'h3F);
    acc(0, 0, 16'h0061, 8'h00);
    acc(0, 0, 16'h0030, 8'h00);
    stop_test;
  end
endmodule : gpbk_port_bench
